/* File: rtl/sacc_pkg.sv */
// Constants, types and reset values of the converter control block.
// Assumes one 100 MHz clock and a single-cycle register port.
//
// Notes on behaviour
// [R01] Eight-bit result by successive approximation, stepped by clock divided by twelve.
// [R02] Writing one to start begins a conversion and clears end-of-conversion at once.
// [R03] Finish sets end-of-conversion; result is valid only while it is set.
// [R04] One conversion per start write; no continuous mode.
// [R05] Start during a running conversion abandons it and begins a fresh one.
// [R06] Start bit is write-only and always reads as zero.
// [R07] Interrupt request when end-of-conversion is set and interrupt enable is one.
// [R08] Power select one keeps converter able to convert; zero puts it idle.
// [R09] Software sets power select at least one instruction before starting.
// [R10] Converter keeps running in processor wait mode; its interrupt can wake it.
// [R11] Reset aborts conversion, control reads 40h, interrupt enable is zero.
// [R12] Software never selects more than one analog input at a time.
// [R13] Control layout: enable bit 7, done bit 6, start bit 5, power bit 4.
// [R14] End-of-conversion is read-only and doubles as interrupt pending bit.
// [R15] Result register is read-only, full eight bits in bits 7 to 0.
// [R16] Conversion lasts about 70 us at 8 MHz, fixing divided clocks per conversion.
// [R17] Writing zero to start changes neither a conversion nor the done flag.
// [R18] Result updates only on completion; aborted conversions keep the old result.

package sacc_pkg;

    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int RES_W  = 8;
    localparam int EVT_W  = 2;
    localparam int TICK_W = 6;
    localparam int IDX_W  = 3;
    localparam int DIV_W  = 4;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [ADDR_W-1:0] ADDR_RESULT     = 8'hD0;
    localparam logic [ADDR_W-1:0] ADDR_CONTROL    = 8'hD1;
    localparam logic [ADDR_W-1:0] ADDR_EVT_STATUS = 8'hDE;
    localparam logic [ADDR_W-1:0] ADDR_EVT_MASK   = 8'hDF;

    localparam int CTL_IRQ_EN_BIT = 7;
    localparam int CTL_EOC_BIT    = 6;
    localparam int CTL_START_BIT  = 5;
    localparam int CTL_POWER_BIT  = 4;
    localparam logic [DATA_W-1:0] CTL_RESET = 8'h40;

    localparam int EVT_DONE_BIT  = 0;
    localparam int EVT_ABORT_BIT = 1;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int DIV_FACTOR   = 12;
    localparam int CONV_TIME_NS = 70000;
    localparam int REF_OSC_KHZ  = 8000;
    localparam int CONV_TICKS   = (CONV_TIME_NS * REF_OSC_KHZ) / (DIV_FACTOR * 1000000);
    localparam int BIT_TICKS    = CONV_TICKS / RES_W;
    localparam int SAMPLE_TICKS = CONV_TICKS - BIT_TICKS * RES_W;
    localparam int CONV_CYCLES  = CONV_TICKS * DIV_FACTOR;

    localparam logic [DIV_W-1:0]  DIV_LAST    = DIV_W'(DIV_FACTOR - 1);
    localparam logic [TICK_W-1:0] SAMPLE_LAST = TICK_W'(SAMPLE_TICKS - 1);
    localparam logic [TICK_W-1:0] BIT_LAST    = TICK_W'(BIT_TICKS - 1);
    localparam logic [IDX_W-1:0]  MSB_IDX     = IDX_W'(RES_W - 1);
    localparam logic [RES_W-1:0]  SAR_INIT    = 8'h80;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_IDLE    = 3'b001,
        ST_SAMPLE  = 3'b010,
        ST_CONVERT = 3'b100
    } sacc_fsm_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } sacc_bus_req_t;

    typedef struct packed {
        sacc_fsm_t         fsm;
        logic              converter_irq_enable;
        logic              converter_power_select;
        logic              eoc;
        logic [EVT_W-1:0]  evt_sts;
        logic [EVT_W-1:0]  evt_msk;
        logic [RES_W-1:0]  result;
        logic [RES_W-1:0]  sar;
        logic [IDX_W-1:0]  bit_idx;
        logic [TICK_W-1:0] tick_cnt;
        logic              sync1;
        logic              sync2;
        logic              busy;
        logic              sampling;
        logic [DATA_W-1:0] rdata;
        logic              irq;
    } sacc_state_t;

    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic             tick;
    } sacc_div_state_t;

endpackage

/* File: rtl/sacc_div12.sv */
// Conversion clock divider: one-cycle tick every twelfth clock.
// Assumes clear is driven from logic on the same clock.

module sacc_div12
    import sacc_pkg::*;
(
    input  wire logic clock,
    input  wire logic reset_n,
    input  wire logic clear,
    output logic      tick
);

    // ****************************************************************
    // State
    // ****************************************************************
    sacc_div_state_t q;
    sacc_div_state_t d;

    always_comb begin
        d = q;
        d.tick = 1'b0;
        if (clear) begin
            d.cnt = '0;
        end else if (q.cnt == DIV_LAST) begin // [R01]
            d.cnt  = '0;
            d.tick = 1'b1;
        end else begin
            d.cnt = q.cnt + DIV_W'(1);
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign tick = q.tick;

endmodule

/* File: rtl/sacc_ctrl.sv */
// Successive-approximation converter control with register port.
// Assumes an external comparator and trial DAC on the analog side;
// comparator answer arrives asynchronously and is synchronised here.

module sacc_ctrl
    import sacc_pkg::*;
(
    input  wire logic          clock,
    input  wire logic          reset_n,
    input  wire sacc_bus_req_t bus_req,
    output logic [DATA_W-1:0]  bus_rdata,
    input  wire logic          comp_above,
    output logic [RES_W-1:0]   dac_code,
    output logic               sample_en,
    output logic               adc_power_on,
    output logic               conv_busy,
    output logic               irq
);

    // ****************************************************************
    // Reset value of all state
    // ****************************************************************
    localparam sacc_state_t STATE_RST = '{
        fsm:      ST_IDLE,
        converter_irq_enable:   CTL_RESET[CTL_IRQ_EN_BIT],
        converter_power_select: CTL_RESET[CTL_POWER_BIT],
        eoc:      CTL_RESET[CTL_EOC_BIT],
        evt_sts:  '0,
        evt_msk:  '0,
        result:   '0,
        sar:      '0,
        bit_idx:  '0,
        tick_cnt: '0,
        sync1:    1'b0,
        sync2:    1'b0,
        busy:     1'b0,
        sampling: 1'b0,
        rdata:    '0,
        irq:      1'b0
    };

    // ****************************************************************
    // Declarations
    // ****************************************************************
    sacc_state_t      q;
    sacc_state_t      d;
    logic             tick;
    logic             div_clear;
    logic             wr_ctl;
    logic             wr_msk;
    logic             rd_sts;
    logic             start_req;
    logic [EVT_W-1:0] evt_set;

    // ****************************************************************
    // Control register view
    // ****************************************************************
    function automatic logic [DATA_W-1:0] ctl_view(
        input sacc_state_t s
    );
        logic [DATA_W-1:0] v;
        v = '0;
        v[CTL_IRQ_EN_BIT] = s.converter_irq_enable; // [R13]
        v[CTL_EOC_BIT]    = s.eoc; // [R13]
        v[CTL_START_BIT]  = 1'b0;  // [R06]
        v[CTL_POWER_BIT]  = s.converter_power_select; // [R13]
        return v;
    endfunction

    // ****************************************************************
    // Read multiplexer
    // ****************************************************************
    function automatic logic [DATA_W-1:0] read_mux(
        input logic [ADDR_W-1:0] addr,
        input sacc_state_t       s
    );
        logic [DATA_W-1:0] v;
        v = '0;
        case (addr)
            ADDR_RESULT: begin
                v = s.result; // [R15]
            end
            ADDR_CONTROL: begin
                v = ctl_view(s);
            end
            ADDR_EVT_STATUS: begin
                v[EVT_W-1:0] = s.evt_sts;
            end
            ADDR_EVT_MASK: begin
                v[EVT_W-1:0] = s.evt_msk;
            end
            default: begin
                v = '0;
            end
        endcase
        return v;
    endfunction

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    assign wr_ctl = bus_req.wr && (bus_req.addr == ADDR_CONTROL);
    assign wr_msk = bus_req.wr && (bus_req.addr == ADDR_EVT_MASK);
    assign rd_sts = bus_req.rd && (bus_req.addr == ADDR_EVT_STATUS);

    // Only a written one starts; a written zero neither starts nor clears the done flag
    assign start_req = wr_ctl && bus_req.wdata[CTL_START_BIT]; // [R17]

    // ****************************************************************
    // Conversion clock divider
    // ****************************************************************
    assign div_clear = start_req || !q.busy;

    sacc_div12 u_div (
        .clock   (clock),
        .reset_n (reset_n),
        .clear   (div_clear),
        .tick    (tick)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        d       = q;
        evt_set = '0;

        // Comparator synchroniser
        d.sync1 = comp_above;
        d.sync2 = q.sync1;

        // Writable control bits
        if (wr_ctl) begin
            d.converter_irq_enable   = bus_req.wdata[CTL_IRQ_EN_BIT]; // [R13]
            d.converter_power_select = bus_req.wdata[CTL_POWER_BIT];  // [R08]
        end

        if (wr_msk) begin
            d.evt_msk = bus_req.wdata[EVT_W-1:0];
        end

        // Sequencer; runs regardless of processor sleep
        if (!start_req) begin // [R10]
            case (q.fsm)
                ST_IDLE: begin
                    d.fsm = ST_IDLE; // [R04]
                end
                ST_SAMPLE: begin
                    if (tick) begin
                        if (q.tick_cnt == SAMPLE_LAST) begin // [R16]
                            d.fsm      = ST_CONVERT;
                            d.tick_cnt = '0;
                            d.sar      = SAR_INIT; // [R01]
                            d.bit_idx  = MSB_IDX;
                        end else begin
                            d.tick_cnt = q.tick_cnt + TICK_W'(1);
                        end
                    end
                end
                ST_CONVERT: begin
                    if (tick) begin
                        if (q.tick_cnt == BIT_LAST) begin // [R16]
                            d.tick_cnt = '0;
                            if (!q.sync2) begin
                                d.sar[q.bit_idx] = 1'b0; // [R01]
                            end
                            if (q.bit_idx == '0) begin
                                d.fsm    = ST_IDLE; // [R04]
                                d.result = d.sar;   // [R18]
                                d.eoc    = 1'b1;    // [R03]
                                evt_set[EVT_DONE_BIT] = 1'b1;
                            end else begin
                                d.sar[q.bit_idx - IDX_W'(1)] = 1'b1; // [R01]
                                d.bit_idx = q.bit_idx - IDX_W'(1);
                            end
                        end else begin
                            d.tick_cnt = q.tick_cnt + TICK_W'(1);
                        end
                    end
                end
                default: begin
                    d.fsm = ST_IDLE;
                end
            endcase
        end

        // Power down stops a running conversion; result kept
        if (!d.converter_power_select && q.fsm != ST_IDLE && !start_req) begin // [R08]
            d.fsm = ST_IDLE;
            evt_set[EVT_ABORT_BIT] = 1'b1;
        end

        // Start: clears done flag, restarts if already running and power select is one
        if (start_req) begin
            d.eoc      = 1'b0; // [R02]
            d.tick_cnt = '0;
            d.sar      = '0;
            d.bit_idx  = '0;
            if (q.fsm != ST_IDLE) begin
                evt_set[EVT_ABORT_BIT] = 1'b1; // [R05]
            end
            if (d.converter_power_select) begin
                d.fsm = ST_SAMPLE; // [R02]
            end else begin
                d.fsm = ST_IDLE; // [R08]
            end
        end

        // Sticky events; a new event beats a clearing read
        for (int i = 0; i < EVT_W; i++) begin
            d.evt_sts[i] = evt_set[i] || (q.evt_sts[i] && !rd_sts);
        end

        // Flop-driven status outputs
        d.busy     = (d.fsm != ST_IDLE);
        d.sampling = (d.fsm == ST_SAMPLE);

        // Done flag doubles as pending bit
        d.irq = (d.eoc && d.converter_irq_enable) // [R07] [R14]
              || |(d.evt_sts & d.evt_msk);

        // Read data for one cycle only
        if (bus_req.rd) begin
            d.rdata = read_mux(bus_req.addr, q);
        end else begin
            d.rdata = '0;
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            q <= STATE_RST; // [R11]
        end else begin
            q <= d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign bus_rdata    = q.rdata;
    assign dac_code     = q.sar;
    assign sample_en    = q.sampling;
    assign adc_power_on = q.converter_power_select;
    assign conv_busy    = q.busy;
    assign irq          = q.irq;

endmodule

/* File: bench/sacc_ctrl_asserts.sv */
// Concurrent checks on the converter control ports.
// Bound to sacc_ctrl; sees only its ports, single clock domain.
module sacc_ctrl_chk
    import sacc_pkg::*;
(
    input wire logic              clock,
    input wire logic              reset_n,
    input wire sacc_bus_req_t     bus_req,
    input wire logic [DATA_W-1:0] bus_rdata,
    input wire logic              comp_above,
    input wire logic [RES_W-1:0]  dac_code,
    input wire logic              sample_en,
    input wire logic              adc_power_on,
    input wire logic              conv_busy,
    input wire logic              irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);

    // ****************************************************************
    // Busy length counter
    // ****************************************************************
    logic        start_wr;
    logic [11:0] len_q;
    logic [11:0] len_d;

    assign start_wr = bus_req.wr && bus_req.addr == ADDR_CONTROL
                      && bus_req.wdata[CTL_START_BIT];

    always_comb begin
        len_d = (conv_busy && !start_wr) ? len_q + 12'h001 : 12'h000;
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            len_q <= 12'h000;
        end else begin
            len_q <= len_d;
        end
    end

    // ****************************************************************
    // Properties
    // ****************************************************************
    start_begins_a: assert property (start_wr && bus_req.wdata[CTL_POWER_BIT]
        |=> conv_busy && sample_en && adc_power_on) else $error("start did not begin");
    no_repeat_a: assert property (!conv_busy && !start_wr |=> !conv_busy)
        else $error("conversion began without start");
    power_off_a: assert property (bus_req.wr && bus_req.addr == ADDR_CONTROL
        && !bus_req.wdata[CTL_POWER_BIT] |=> !adc_power_on && !conv_busy)
        else $error("power down not taken");
    idle_power_a: assert property (!adc_power_on |-> !conv_busy)
        else $error("busy while powered down");
    rdata_idle_a: assert property (!bus_req.rd |=> bus_rdata == 8'h00)
        else $error("read data outside read slot");
    ctl_fixed_a: assert property (bus_req.rd && bus_req.addr == ADDR_CONTROL
        |=> bus_rdata[CTL_START_BIT] == 1'b0 && bus_rdata[3:0] == 4'h0
        && bus_rdata[CTL_POWER_BIT] == adc_power_on) else $error("control readback wrong");
    irq_cause_a: assert property ($rose(irq) |-> $past(bus_req.wr)
        || $past(bus_req.wr, 2) || $past(conv_busy) || $past(conv_busy, 2))
        else $error("interrupt without cause");
    sample_busy_a: assert property (sample_en |-> conv_busy)
        else $error("sampling outside conversion");
    sar_start_a: assert property ($fell(sample_en) && conv_busy |-> dac_code == SAR_INIT)
        else $error("first trial code wrong");
    conv_max_a: assert property (conv_busy |-> len_q <= 12'(CONV_CYCLES + 4))
        else $error("conversion too long");
    conv_min_a: assert property ($fell(conv_busy) && !$past(bus_req.wr)
        |-> $past(len_q) >= 12'(CONV_CYCLES - 4)) else $error("conversion too short");

    done_c: cover property ($fell(conv_busy) && !$past(bus_req.wr));
    restart_c: cover property (conv_busy && start_wr);
    irq_c: cover property ($rose(irq));
endmodule

bind sacc_ctrl sacc_ctrl_chk u_chk (.clock(clock), .reset_n(reset_n), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .comp_above(comp_above), .dac_code(dac_code),
    .sample_en(sample_en), .adc_power_on(adc_power_on), .conv_busy(conv_busy), .irq(irq));

/* File: bench/sacc_ain_model.sv */
// Analog input and comparator model for the converter.
// Assumes one selected input at the given level, comparator delayed.
module sacc_ain_model
    import sacc_pkg::*;
(
    input wire logic [RES_W-1:0] dac_code,
    input wire logic [RES_W-1:0] level,
    input wire logic             powered,
    output logic                 comp_above
);
    timeunit 1ns;
    timeprecision 1ps;
    // Single input compared with trial code; unpowered output is the inverted comparison
    assign #3 comp_above = powered ? (level >= dac_code) : ~(level >= dac_code);
endmodule

/* File: bench/tb_sar_adc_control.sv */
// Self-checking bench for the converter control block.
// Assumes sacc_ctrl, its checker and the analog input model.
module tb_sar_adc_control
    import sacc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic             clock = 1'b0;
    logic             reset_n;
    sacc_bus_req_t    bus_req;
    logic [7:0]       bus_rdata;
    logic [7:0]       dac_code;
    logic [7:0]       level;
    logic             comp_above;
    logic             sample_en;
    logic             adc_power_on;
    logic             conv_busy;
    logic             irq;
    int               n_errors = 0;
    int               n_checks = 0;
    logic             m_en, m_eoc, m_pwr;
    logic [7:0]       m_res, m_evt;

    always #5 clock = ~clock;

    sacc_ctrl uut (.clock(clock), .reset_n(reset_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .comp_above(comp_above), .dac_code(dac_code), .sample_en(sample_en),
        .adc_power_on(adc_power_on), .conv_busy(conv_busy), .irq(irq));
    sacc_ain_model u_ain (.dac_code(dac_code), .level(level), .powered(adc_power_on),
        .comp_above(comp_above));

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        bus_req.wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string n);
        @(posedge clock);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        bus_req.rd <= 1'b0;
        #1 chk(n, e, bus_rdata);
    endtask
    function automatic logic [7:0] sar_model(input int v);
        int c;
        c = 0;
        for (int b = 7; b >= 0; b--) if (v >= (c | (1 << b))) c = c | (1 << b);
        return 8'(c);
    endfunction
    task automatic start(input logic [7:0] v);
        level = v;
        if (!m_pwr) wr_reg(ADDR_CONTROL, {m_en, 3'b001, 4'h0});
        wr_reg(ADDR_CONTROL, {m_en, 3'b011, 4'($urandom)});
        m_eoc = 1'b0;
        m_pwr = 1'b1;
    endtask
    task automatic finish();
        int k;
        k = 0;
        #1;
        while (conv_busy !== 1'b0 && k < 1000) begin
            @(posedge clock);
            #1 k++;
        end
        n_checks++;
        if (k < CONV_CYCLES - 4 || k > CONV_CYCLES + 4) begin
            n_errors++;
            $display("unexpected conversion length: expected %0d, seen %0d", CONV_CYCLES, k);
        end
        m_eoc = 1'b1;
        m_res = sar_model(int'(level));
        m_evt = m_evt | 8'h01;
    endtask
    task automatic end_sim();
        $display("checks %0d, errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // ****************************************************************
    // Sequence
    // ****************************************************************
    initial begin
        #200000 n_errors++;
        end_sim();
    end

    initial begin
        bus_req = '0;
        level = 8'h00;
        reset_n = 1'b0;
        {m_en, m_eoc, m_pwr, m_res, m_evt} = {3'b010, 16'h0000};
        void'($urandom(32'h5E2C87DA));
        repeat (10) @(posedge clock);
        reset_n <= 1'b1;
        rd_chk(ADDR_CONTROL, 8'h40, "control");
        rd_chk(8'h55, 8'h00, "unmapped");
        wr_reg(ADDR_RESULT, 8'hA5);
        rd_chk(ADDR_RESULT, 8'h00, "result");
        wr_reg(ADDR_CONTROL, 8'h00);
        rd_chk(ADDR_CONTROL, 8'h40, "control");
        wr_reg(ADDR_CONTROL, 8'h20);
        m_eoc = 1'b0;
        #1 chk("busy", 8'h00, {7'h0, conv_busy});
        for (int i = 0; i < 4; i++) begin
            m_en = i[0];
            wr_reg(ADDR_EVT_MASK, {7'h00, i[1]});
            rd_chk(ADDR_EVT_MASK, {7'h00, i[1]}, "mask");
            rd_chk(ADDR_EVT_STATUS, m_evt, "status");
            m_evt = 8'h00;
            start(8'($urandom));
            wr_reg(ADDR_CONTROL, {m_en, 3'b001, 4'h0});
            rd_chk(ADDR_CONTROL, {m_en, 3'b001, 4'h0}, "control");
            finish();
            chk("irq", {7'h0, m_en | i[1]}, {7'h0, irq});
            chk("dac_code", m_res, dac_code);
            rd_chk(ADDR_CONTROL, {m_en, m_eoc, 2'b01, 4'h0}, "control");
            rd_chk(ADDR_RESULT, m_res, "result");
            rd_chk(ADDR_EVT_STATUS, m_evt, "status");
            m_evt = 8'h00;
            #1 chk("irq", {7'h0, m_en}, {7'h0, irq});
        end
        start(8'h3C);
        repeat (200) @(posedge clock);
        start(8'hC3);
        m_evt = 8'h02;
        finish();
        rd_chk(ADDR_RESULT, 8'hC3, "result");
        rd_chk(ADDR_EVT_STATUS, 8'h03, "status");
        start(8'h11);
        repeat (100) @(posedge clock);
        wr_reg(ADDR_CONTROL, 8'h00);
        m_pwr = 1'b0;
        #1 chk("busy", 8'h00, {7'h0, conv_busy});
        rd_chk(ADDR_RESULT, 8'hC3, "result");
        rd_chk(ADDR_CONTROL, 8'h00, "control");
        rd_chk(ADDR_EVT_STATUS, 8'h02, "status");
        m_en = 1'b1;
        start(8'h5A);
        repeat (50) @(posedge clock);
        reset_n <= 1'b0;
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        #1 chk("busy", 8'h00, {7'h0, conv_busy});
        chk("irq", 8'h00, {7'h0, irq});
        rd_chk(ADDR_CONTROL, 8'h40, "control");
        rd_chk(ADDR_RESULT, 8'h00, "result");
        end_sim();
    end
endmodule
